// ---- design/ppc_pkg.sv ----
package ppc_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_IN_LO   = 8'h00;
   localparam logic [7:0] ADDR_IN_HI   = 8'h01;
   localparam logic [7:0] ADDR_PH0_LO  = 8'h02;
   localparam logic [7:0] ADDR_PH0_HI  = 8'h03;
   localparam logic [7:0] ADDR_DIR_LO  = 8'h06;
   localparam logic [7:0] ADDR_DIR_HI  = 8'h07;
   localparam logic [7:0] ADDR_PH1_LO  = 8'h0a;
   localparam logic [7:0] ADDR_PH1_HI  = 8'h0b;
   localparam logic [7:0] ADDR_MASTER  = 8'h0e;
   localparam logic [7:0] ADDR_CFG     = 8'h0f;
   localparam logic [7:0] ADDR_INT_LO  = 8'h10;
   localparam logic [7:0] ADDR_INT_HI  = 8'h17;
   // ---------------------------------------------------------------
   // configuration fields
   // ---------------------------------------------------------------
   localparam int CFG_ALT    = 0;
   localparam int CFG_FLIP   = 1;
   localparam int CFG_GLOBAL = 2;
   localparam int CFG_O16_P0 = 4;
   localparam int CFG_O16_P1 = 5;
   localparam int CFG_PIN    = 6;
   localparam logic [7:0] CFG_WMASK = 8'h37;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] PH_RST     = 16'hffff;
   localparam logic [15:0] DIR_RST    = 16'hffff;
   localparam logic [7:0]  CFG_RST    = 8'h30;
   localparam logic [7:0]  MASTER_RST = 8'h00;
   localparam logic [63:0] INT_RST    = 64'hffff_ffff_ffff_ffff;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CLK_HZ      = 250_000_000;
   localparam int          OSC_HZ      = 32_000;
   localparam int          OSC_DIV_DEF = CLK_HZ / OSC_HZ;
   localparam logic [3:0]  CYC_LAST    = 4'hf;
   localparam logic [3:0]  SLOT_LAST   = 4'he;
   localparam logic [3:0]  INT_FULL    = 4'hf;
endpackage

// ---- design/ppc_port_control.sv ----
module ppc_port_control
   import ppc_pkg::*;
#(
   parameter int OSC_DIV = OSC_DIV_DEF
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   input  wire logic        toggle_pin_in,
   input  wire logic [15:0] io_ports_in,
   output logic      [15:0] io_ports_out,
   output logic      [15:0] io_ports_oe_out,
   output logic             seventeenth_output_out,
   output logic             seventeenth_output_oe_out
);
   if (OSC_DIV < 2 || OSC_DIV > 8191) begin : g_chk
      $error("OSC_DIV out of range");
   end

   typedef struct packed {
      logic [15:0] in_s1;
      logic [15:0] in_s2;
      logic        tg_s1;
      logic        tg_s2;
      logic [15:0] ph0;
      logic [15:0] ph1;
      logic [15:0] dir;
      logic [7:0]  cfg;
      logic [7:0]  master;
      logic [63:0] inten;
      logic [12:0] div;
      logic [3:0]  cyc;
      logic [3:0]  slot;
      logic [7:0]  rdata;
      logic [15:0] oe;
      logic        o16_oe;
   } ppc_state_t;

   ppc_state_t st;
   ppc_state_t next_st;

   // ---------------------------------------------------------------
   // phase selection and pwm gating
   // ---------------------------------------------------------------
   logic        alt_sel;
   logic [15:0] lvl;
   logic [15:0] on_time;
   logic        pwm_on;
   logic        tick;
   logic        o16_lvl;
   logic        o16_on;

   assign pwm_on  = st.master[7:4] != 4'h0;
   assign tick    = pwm_on && st.div == 13'(OSC_DIV - 1);
   assign alt_sel = st.cfg[CFG_ALT] & (st.cfg[CFG_FLIP] ^ st.tg_s2);
   assign lvl     = alt_sel ? st.ph1 : st.ph0;
   assign o16_lvl = alt_sel ? st.cfg[CFG_O16_P1] : st.cfg[CFG_O16_P0];
   assign o16_on  = !pwm_on || st.master[3:0] == INT_FULL
                    || (st.slot < st.master[7:4] && st.cyc <= st.master[3:0]);

   for (genvar i = 0; i < 16; i++) begin : g_port
      logic [3:0] val;
      // global setting replaces all individual ones
      assign val = st.cfg[CFG_GLOBAL] ? st.master[3:0] : st.inten[4*i +: 4];
      // full intensity or pwm off gives a static level
      assign on_time[i] = !pwm_on || val == INT_FULL
                          || (st.slot < st.master[7:4] && st.cyc <= val);
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] drv;
      drv = '0;
      next_st = st;
      next_st.in_s1 = io_ports_in;
      next_st.in_s2 = st.in_s1;
      next_st.tg_s1 = toggle_pin_in;
      next_st.tg_s2 = st.tg_s1;

      if (reg_wr_in) begin
         unique case (reg_addr_in)
            ADDR_PH0_LO: next_st.ph0[7:0]  = reg_wdata_in;
            ADDR_PH0_HI: next_st.ph0[15:8] = reg_wdata_in;
            ADDR_PH1_LO: next_st.ph1[7:0]  = reg_wdata_in;
            ADDR_PH1_HI: next_st.ph1[15:8] = reg_wdata_in;
            ADDR_DIR_LO: next_st.dir[7:0]  = reg_wdata_in;
            ADDR_DIR_HI: next_st.dir[15:8] = reg_wdata_in;
            ADDR_MASTER: next_st.master    = reg_wdata_in;
            ADDR_CFG:    next_st.cfg       = reg_wdata_in & CFG_WMASK;
            default: begin
               if (reg_addr_in >= ADDR_INT_LO && reg_addr_in <= ADDR_INT_HI) begin
                  next_st.inten[8*reg_addr_in[2:0] +: 8] = reg_wdata_in;
               end
            end
         endcase
      end

      if (reg_rd_in) begin
         unique case (reg_addr_in)
            ADDR_IN_LO:  next_st.rdata = st.in_s2[7:0];
            ADDR_IN_HI:  next_st.rdata = st.in_s2[15:8];
            ADDR_PH0_LO: next_st.rdata = st.ph0[7:0];
            ADDR_PH0_HI: next_st.rdata = st.ph0[15:8];
            ADDR_PH1_LO: next_st.rdata = st.ph1[7:0];
            ADDR_PH1_HI: next_st.rdata = st.ph1[15:8];
            ADDR_DIR_LO: next_st.rdata = st.dir[7:0];
            ADDR_DIR_HI: next_st.rdata = st.dir[15:8];
            ADDR_MASTER: next_st.rdata = st.master;
            ADDR_CFG:    next_st.rdata = st.cfg | {1'b0, st.tg_s2, 6'h00};
            default: begin
               if (reg_addr_in >= ADDR_INT_LO && reg_addr_in <= ADDR_INT_HI) begin
                  next_st.rdata = st.inten[8*reg_addr_in[2:0] +: 8];
               end else begin
                  next_st.rdata = 8'h00;
               end
            end
         endcase
      end

      // oscillator and step counters, cleared to zero while pwm is off
      if (!pwm_on) begin
         next_st.div  = '0;
         next_st.cyc  = '0;
         next_st.slot = '0;
      end else if (tick) begin
         next_st.div = '0;
         next_st.cyc = st.cyc + 4'h1;
         if (st.cyc == CYC_LAST) begin
            next_st.slot = (st.slot == SLOT_LAST) ? 4'h0 : st.slot + 4'h1;
         end
      end else begin
         next_st.div = st.div + 13'h1;
      end

      // off-time drives the opposite of the phase level
      drv = lvl ^ ~on_time;
      next_st.oe = ~st.dir & ~drv;
      next_st.o16_oe = !(o16_on ? o16_lvl : !o16_lvl);
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '{in_s1: 16'h0000, in_s2: 16'h0000, tg_s1: 1'b0, tg_s2: 1'b0,
                 ph0: PH_RST, ph1: PH_RST, dir: DIR_RST, cfg: CFG_RST,
                 master: MASTER_RST, inten: INT_RST, div: 13'h0000,
                 cyc: 4'h0, slot: 4'h0, rdata: 8'h00, oe: 16'h0000,
                 o16_oe: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_out             = st.rdata;
   assign io_ports_out              = 16'h0000;
   assign io_ports_oe_out           = st.oe;
   assign seventeenth_output_out    = 1'b0;
   assign seventeenth_output_oe_out = st.o16_oe;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   phase_xor_a: assert property (
      st.cfg[CFG_ALT] && (st.cfg[CFG_FLIP] ^ st.tg_s2) |-> lvl == st.ph1)
      else $error("phase-1 not selected");
   alt_off_a: assert property (
      !st.cfg[CFG_ALT] |-> lvl == st.ph0 && !alt_sel)
      else $error("phase-0 not used with alternation off");
   alt_write_a: assert property (
      reg_wr_in && reg_addr_in == ADDR_CFG |=> st.cfg[CFG_ALT] == $past(reg_wdata_in[0]))
      else $error("alternate enable not stored");
   drive_low_a: assert property (
      !pwm_on && !st.dir[0] && !st.cfg[CFG_ALT] ##1 !pwm_on[*1]
      |-> st.oe[0] == !$past(st.ph0[0]))
      else $error("static port level wrong");
   input_hiz_a: assert property (
      st.dir[3] |=> !st.oe[3])
      else $error("input port driven");
   dir_read_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_DIR_HI |=> reg_rdata_out == $past(st.dir[15:8]))
      else $error("direction readback wrong");
   in_read_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_IN_LO |=> reg_rdata_out == $past(st.in_s2[7:0]))
      else $error("input readback wrong");
   ph_store_a: assert property (
      reg_wr_in && reg_addr_in == ADDR_PH0_LO ##1 !reg_wr_in
      ##1 reg_rd_in && !reg_wr_in && reg_addr_in == ADDR_PH0_LO
      |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("phase readback not stored value");
   osc_stop_a: assert property (
      !pwm_on |=> st.div == 13'h0000 && st.slot == 4'h0 && st.cyc == 4'h0)
      else $error("oscillator runs with pwm off");
   slot_wrap_a: assert property (
      tick && st.cyc == CYC_LAST && st.slot == SLOT_LAST && pwm_on
      |=> st.slot == 4'h0 && st.cyc == 4'h0)
      else $error("pwm period not 240 steps");
   master_gate_a: assert property (
      pwm_on && st.slot >= st.master[7:4] && g_port[0].val != INT_FULL |-> !on_time[0])
      else $error("output on outside master slots");
   full_bypass_a: assert property (
      g_port[1].val == INT_FULL && !st.dir[1] |=> st.oe[1] == !$past(lvl[1]))
      else $error("full intensity not static");
   sync_pin_a: assert property (
      !$past(rst_in, 2) |-> st.tg_s2 == $past(toggle_pin_in, 2))
      else $error("toggle pin sync depth wrong");
   tg_first_a: assert property (
      !$past(rst_in) |-> st.tg_s1 == $past(toggle_pin_in))
      else $error("toggle pin first stage wrong");
   in_sync_a: assert property (
      !$past(rst_in, 2) |-> st.in_s2 == $past(io_ports_in, 2))
      else $error("port input sync depth wrong");
   in_hi_read_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_IN_HI |=> reg_rdata_out == $past(st.in_s2[15:8]))
      else $error("high input readback wrong");
   dir_lo_read_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_DIR_LO |=> reg_rdata_out == $past(st.dir[7:0]))
      else $error("low direction readback wrong");
   ph1_read_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_PH1_HI |=> reg_rdata_out == $past(st.ph1[15:8]))
      else $error("phase-1 readback wrong");
   ph0_hi_read_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_PH0_HI |=> reg_rdata_out == $past(st.ph0[15:8]))
      else $error("phase-0 high readback wrong");
   cfg_mask_a: assert property (
      reg_wr_in && reg_addr_in == ADDR_CFG |=> st.cfg == ($past(reg_wdata_in) & CFG_WMASK))
      else $error("configuration not stored");
   cfg_read_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_CFG
      |=> reg_rdata_out[1:0] == $past(st.cfg[1:0]) && reg_rdata_out[CFG_PIN] == $past(st.tg_s2))
      else $error("configuration readback wrong");
   ph1_store_a: assert property (
      reg_wr_in && reg_addr_in == ADDR_PH1_LO |=> st.ph1[7:0] == $past(reg_wdata_in))
      else $error("phase-1 write not stored");
   dir_store_a: assert property (
      reg_wr_in && reg_addr_in == ADDR_DIR_LO |=> st.dir[7:0] == $past(reg_wdata_in))
      else $error("direction write not stored");
   hiz_level_a: assert property (
      !pwm_on && lvl[1] |=> !st.oe[1])
      else $error("high phase bit pulls pin low");
   dir_mask_a: assert property (
      (st.oe & $past(st.dir)) == 16'h0000)
      else $error("input port driven low");
   ph1_drive_a: assert property (
      !pwm_on && alt_sel && !st.dir[0] |=> st.oe[0] == !$past(st.ph1[0]))
      else $error("phase-1 level not driven");
   o16_phase0_a: assert property (
      !pwm_on && !alt_sel |=> st.o16_oe == !$past(st.cfg[CFG_O16_P0]))
      else $error("extra output phase-0 level wrong");
   o16_phase1_a: assert property (
      !pwm_on && alt_sel |=> st.o16_oe == !$past(st.cfg[CFG_O16_P1]))
      else $error("extra output phase-1 level wrong");
   div_count_a: assert property (
      pwm_on && !tick |=> st.div == $past(st.div) + 13'h1)
      else $error("oscillator divider not counting");
   div_range_a: assert property (
      st.div < 13'(OSC_DIV))
      else $error("oscillator divider past its end");
   cyc_step_a: assert property (
      tick |=> st.cyc == $past(st.cyc) + 4'h1)
      else $error("pwm cycle not stepped");
   cyc_hold_a: assert property (
      pwm_on && !tick |=> st.cyc == $past(st.cyc) && st.slot == $past(st.slot))
      else $error("pwm step moved without tick");
   slot_range_a: assert property (
      st.slot <= SLOT_LAST)
      else $error("more than 15 timeslots");
   slot_step_a: assert property (
      tick && st.cyc == CYC_LAST && st.slot != SLOT_LAST |=> st.slot == $past(st.slot) + 4'h1)
      else $error("timeslot not stepped");
   off_drive_a: assert property (
      pwm_on && !on_time[0] && !st.dir[0] |=> st.oe[0] == $past(lvl[0]))
      else $error("off-time level wrong");
   on_drive_a: assert property (
      pwm_on && on_time[0] && !st.dir[0] |=> st.oe[0] == !$past(lvl[0]))
      else $error("on-time level wrong");
   global_same_a: assert property (
      st.cfg[CFG_GLOBAL] |-> on_time == {16{on_time[0]}})
      else $error("global intensity not shared");
endmodule

// ---- verif/ppc_load_model.sv ----
// ---------------------------------------------------------------
// pulled-up loads on the open-drain port pins
// ---------------------------------------------------------------
module ppc_load_model (
   input  wire logic [15:0] oe_in,
   input  wire logic [15:0] pull_low_in,
   output logic      [15:0] level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pin is pulled high unless the outside logic sinks it
   assign level_out = ~(oe_in | pull_low_in);
endmodule

// ---- verif/port_phase_pwm_control_tb.sv ----
module port_phase_pwm_control_tb;
   import ppc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_in, rst_in, wr, rd, tgl, o17_oe, o17;
   logic [7:0]  addr, wdata, rdata, v;
   logic [15:0] pins, oe, ext_low, pout;
   int          error_cnt, checks, c0, c1;
   ppc_port_control #(.OSC_DIV(4)) uut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .toggle_pin_in(tgl), .io_ports_in(pins),
      .io_ports_out(pout), .io_ports_oe_out(oe), .seventeenth_output_out(o17),
      .seventeenth_output_oe_out(o17_oe));
   ppc_load_model load (.oe_in(oe), .pull_low_in(ext_low), .level_out(pins));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in) #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk_sys_in) #1;
      wr = 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a);
      @(posedge clk_sys_in) #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk_sys_in) #1;
      rd = 1'b0;
      v = rdata;
   endtask
   task automatic settle;
      repeat (6) @(posedge clk_sys_in);
      #1;
   endtask
   // counts drive cycles of ports 0 and 1 over one full pwm period
   task automatic count;
      repeat (1000) @(posedge clk_sys_in);
      c0 = 0;
      c1 = 0;
      repeat (960) begin
         @(posedge clk_sys_in) #1;
         c0 += int'(oe[0]);
         c1 += int'(oe[1]);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] ra [6] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h0a, 8'h0b};
      foreach (ra[i]) begin
         rd8(ra[i]);
         chk({8'h00, v}, 16'h00ff);
      end
      rd8(8'h0f);
      chk({8'h00, v}, 16'h0030);
      chk(oe, 16'h0000);
      chk(pout, 16'h0000);
      chk({15'h0, o17}, 16'h0000);
   endtask
   task automatic t_static;
      wr8(8'h06, 8'h00);
      wr8(8'h02, 8'h5a);
      rd8(8'h02);
      chk({8'h00, v}, 16'h005a);
      ext_low = 16'h0f00;
      settle();
      chk(oe, 16'h00a5);
      wr8(8'h00, 8'h00);
      rd8(8'h00);
      chk({8'h00, v}, 16'h005a);
      rd8(8'h01);
      chk({8'h00, v}, 16'h00f0);
   endtask
   task automatic t_alt;
      logic f;
      logic t;
      wr8(8'h02, 8'h00);
      wr8(8'h0a, 8'hff);
      wr8(8'h0b, 8'hff);
      tgl = 1'b1;
      settle();
      chk(oe, 16'h00ff);
      for (int i = 0; i < 4; i++) begin
         f = i[1];
         t = i[0];
         wr8(8'h0f, {6'h08, f, 1'b1});
         tgl = t;
         settle();
         chk(oe, (f ^ t) ? 16'h0000 : 16'h00ff);
         chk({15'h0, o17_oe}, {15'h0, ~(f ^ t)});
      end
      wr8(8'h0f, 8'h22);
      settle();
      chk(oe, 16'h00ff);
      chk({15'h0, o17_oe}, 16'h0001);
      rd8(8'h0f);
      chk({8'h00, v}, 16'h0062);
   endtask
   task automatic t_pwm;
      wr8(8'h10, 8'hf0);
      wr8(8'h0f, 8'h20);
      wr8(8'h0e, 8'h10);
      count();
      chk(16'(c0), 16'd4);
      chk(16'(c1), 16'd960);
      wr8(8'h0f, 8'h24);
      count();
      chk(16'(c1), 16'd4);
      wr8(8'h0e, 8'h00);
      count();
      chk(16'(c0), 16'd960);
   endtask
   // ---------------------------------------------------------------
   // clock, watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      repeat (50000) @(posedge clk_sys_in);
      error_cnt++;
      results();
   end
   initial begin
      {wr, rd, tgl, addr, wdata, ext_low} = '0;
      error_cnt = 0;
      checks = 0;
      rst_in = 1'b1;
      repeat (16) @(posedge clk_sys_in);
      #1;
      rst_in = 1'b0;
      t_reset();
      t_static();
      t_alt();
      t_pwm();
      results();
   end
endmodule
